// File: logic/tpc_defs.vh
// Constants for one timer channel: register map, fields, reset values.
// Included by every design file of the channel; definitions only.
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// Register byte addresses on the 32-bit bus
`define TPC_OFF_CTRL 4'h0
`define TPC_OFF_VAL_HI 4'h4
`define TPC_OFF_VAL_LO 4'h8
`define TPC_OFF_STAT 4'hc

// Control/status field positions
`define TPC_MS_HI_BIT 5
`define TPC_MS_LO_BIT 4
`define TPC_ELS_HI_BIT 3
`define TPC_ELS_LO_BIT 2

// Buffer state register field positions
`define TPC_ST_RLATCH_BIT 0
`define TPC_ST_GOT_HI_BIT 1
`define TPC_ST_GOT_LO_BIT 2
`define TPC_ST_PEND_BIT 3

// Reset values
`define TPC_CTRL_RST 2'b00
`define TPC_VAL_RST 16'h0000

// Encodings
`define TPC_ELS_OFF 2'b00
`define TPC_CLK_NONE 2'b00
`define TPC_TERM_FREE 16'hffff
`define TPC_MOD_FREE 16'h0000

// Bus answers
`define TPC_RESP_OKAY 2'b00
`define TPC_RESP_SLVERR 2'b10

`endif

// File: logic/tpc_axil_slave.v
// AXI4-Lite slave front end: turns bus transfers into one-cycle strobes.
// Assumes the register side acts on a strobe at the edge that ends it.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.vh"
module tpc_axil_slave (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire wr_stb,
	output wire [3:0] wr_addr,
	output wire [7:0] wr_data,
	output wire rd_stb,
	output wire [3:0] rd_addr,
	input wire [7:0] rd_data
);
	reg [31:0] awaddr_q;
	reg [31:0] wdata_q;
	reg wlane_q;
	reg [31:0] araddr_q;
	reg aw_got_q;
	reg w_got_q;
	reg ar_got_q;
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire wr_ok = mapped(awaddr_q);
	wire rd_ok = mapped(araddr_q);

	function mapped;
		input [31:0] a;
		begin
			mapped = (a[31:4] == 28'h0000000) && (a[1:0] == 2'b00);
		end
	endfunction

	// Only lane 0 carries register bits; other lanes are dropped
	assign wr_stb = aw_got_q & w_got_q & ~s_axi_bvalid & wr_ok & wlane_q;
	assign wr_addr = awaddr_q[3:0];
	assign wr_data = wdata_q[7:0];
	assign rd_stb = ar_got_q & ~s_axi_rvalid & rd_ok;
	assign rd_addr = araddr_q[3:0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_arready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TPC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `TPC_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			awaddr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			wlane_q <= 1'b0;
			araddr_q <= 32'h00000000;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			ar_got_q <= 1'b0;
		end else begin
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr;
				aw_got_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				wdata_q <= s_axi_wdata;
				wlane_q <= s_axi_wstrb[0];
				w_got_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (ar_hs) begin
				araddr_q <= s_axi_araddr;
				ar_got_q <= 1'b1;
				s_axi_arready <= 1'b0;
			end
			if (ar_got_q && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_ok ? {24'h000000, rd_data} : 32'h00000000;
				s_axi_rresp <= rd_ok ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
				ar_got_q <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: logic/tpc_pin_ctrl.v
// Pin side of the channel: edge detection for capture, compare and PWM drive.
// Assumes the counter value and its change pulse come from the shared counter.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.vh"
module tpc_pin_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire [1:0] mode_sel,
	input wire [1:0] edge_level_sel,
	input wire center_pwm_select,
	input wire [15:0] chan_value,
	input wire [15:0] cnt_value,
	input wire cnt_tick,
	input wire cnt_up,
	input wire pin_in,
	output wire capture_stb,
	output reg pin_out,
	output reg pin_oe
);
	reg pin_prev_q;
	wire els_off = (edge_level_sel == `TPC_ELS_OFF);
	wire is_ic = ~center_pwm_select & (mode_sel == 2'b00);
	wire is_oc = ~center_pwm_select & (mode_sel == 2'b01);
	wire is_edge_aligned_pulse_mode = ~center_pwm_select & mode_sel[1];
	wire rise = pin_in & ~pin_prev_q;
	wire fall = ~pin_in & pin_prev_q;
	wire match = cnt_tick & (cnt_value == chan_value);
	wire low_true = edge_level_sel[0];

	// Pin must be steady two cycles before entering capture, else a false edge
	assign capture_stb = is_ic & ~els_off &
		((edge_level_sel[0] & rise) | (edge_level_sel[1] & fall)); // RULE2 RULE6

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_prev_q <= 1'b0;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_prev_q <= pin_in;
			pin_oe <= ~els_off & ~is_ic; // RULE1
			if (els_off) begin
				pin_out <= 1'b0; // RULE1
			end else if (is_oc) begin
				if (match) begin
					case (edge_level_sel) // RULE3
						2'b01: pin_out <= ~pin_out;
						2'b10: pin_out <= 1'b0;
						2'b11: pin_out <= 1'b1;
						default: pin_out <= pin_out;
					endcase
				end
			end else if (is_edge_aligned_pulse_mode) begin
				// Compare wins over period start, so a zero value gives 0% duty
				if (match)
					pin_out <= low_true; // RULE4
				else if (cnt_tick && cnt_value == 16'h0000)
					pin_out <= ~low_true; // RULE4
			end else if (center_pwm_select) begin
				if (match && cnt_up)
					pin_out <= low_true; // RULE5
				else if (match)
					pin_out <= ~low_true; // RULE5
			end
		end
	end
endmodule
`default_nettype wire

// File: logic/tpc_channel.v
// One channel of a 16-bit timer: mode control, value register and its buffers.
// Assumes a shared counter outside that supplies its value, change pulse and
// direction, plus the modulo, clock select and center mode of the module.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.vh"
// Notes on behaviour
// RULE1: Edge/level 00 frees pin for general use
// RULE2: Capture mode: rise, fall or either edge
// RULE3: Compare mode: toggle, clear or set on match
// RULE4: Edge PWM: high-true or low-true pulses
// RULE5: Center select forces center PWM, compare-up edge
// RULE6: Pin stable two cycles before entering capture
// RULE7: Reset clears both value bytes
// RULE8: Capture mode reads latch both bytes coherently
// RULE9: Control write releases the read latch; here a first read in the same cycle still latches
// RULE10: Value writes ignored in capture mode
// RULE11: Debug halt freezes read latch state
// RULE12: Debug halt reads return live register
// RULE13: Compare/PWM writes buffered until both bytes
// RULE14: Bytes may arrive high or low first
// RULE15: No counter clock: load on second byte
// RULE16: Compare mode loads at next counter change
// RULE17: PWM loads at step to terminal count
// RULE18: Control write clears partial write sequence
// RULE19: Debug halt writes go straight to register
// RULE20: Halt writes keep pending sequence intact
// RULE21: Center select makes counter count up/down
// RULE22: Active capture edge copies counter into value
module tpc_channel (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] cnt_value,
	input wire cnt_tick,
	input wire cnt_up,
	input wire [15:0] counter_modulo,
	input wire [1:0] counter_clock_select,
	input wire center_pwm_select,
	input wire debug_halt_mode,
	input wire pin_in,
	output wire pin_out,
	output wire pin_oe,
	output reg count_up_down_q,
	output reg [15:0] chan_value_q
);
	// Control fields
	reg [1:0] mode_sel_q;
	reg [1:0] edge_level_sel_q;

	// Read coherency state
	reg rlatch_q;
	reg rfirst_hi_q;
	reg [15:0] rbuf_q;

	// Write coherency state
	reg got_hi_q;
	reg got_lo_q;
	reg pend_q;
	reg [7:0] wbuf_hi_q;
	reg [7:0] wbuf_lo_q;

	wire wr_stb;
	wire [3:0] wr_addr;
	wire [7:0] wr_data;
	wire rd_stb;
	wire [3:0] rd_addr;
	reg [7:0] rd_data;
	wire capture_stb;

	wire is_ic = ~center_pwm_select & (mode_sel_q == 2'b00);
	wire is_oc = ~center_pwm_select & (mode_sel_q == 2'b01);
	wire is_pwm = center_pwm_select | mode_sel_q[1];
	wire clk_off = (counter_clock_select == `TPC_CLK_NONE);

	wire wr_ctrl = wr_stb & (wr_addr == `TPC_OFF_CTRL);
	wire wr_hi = wr_stb & (wr_addr == `TPC_OFF_VAL_HI);
	wire wr_lo = wr_stb & (wr_addr == `TPC_OFF_VAL_LO);
	wire rd_hi = rd_stb & (rd_addr == `TPC_OFF_VAL_HI);
	wire rd_lo = rd_stb & (rd_addr == `TPC_OFF_VAL_LO);

	// A buffered write completes when this write supplies the missing byte
	wire wr_val = (wr_hi | wr_lo) & ~is_ic & ~debug_halt_mode;
	wire completes = (wr_hi & got_lo_q) | (wr_lo & got_hi_q); // RULE14
	// Halt write owns the value this cycle; a pending pair waits its next chance
	wire halt_wr = debug_halt_mode & (wr_hi | wr_lo) & ~is_ic;

	function [15:0] term_count;
		input [15:0] modulo;
		begin
			if (modulo == `TPC_MOD_FREE)
				term_count = `TPC_TERM_FREE;
			else
				term_count = modulo;
		end
	endfunction

	// Counter stepping onto the terminal count, upward only
	wire at_term = cnt_tick & cnt_up & (cnt_value == term_count(counter_modulo));

	// Load of a complete pair waiting for its moment
	wire pend_load = pend_q & (clk_off |
		(is_oc & cnt_tick) | // RULE16
		(is_pwm & at_term)); // RULE17

	tpc_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_stb(rd_stb),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	tpc_pin_ctrl u_pin (
		.aclk(aclk),
		.aresetn(aresetn),
		.mode_sel(mode_sel_q),
		.edge_level_sel(edge_level_sel_q),
		.center_pwm_select(center_pwm_select),
		.chan_value(chan_value_q),
		.cnt_value(cnt_value),
		.cnt_tick(cnt_tick),
		.cnt_up(cnt_up),
		.pin_in(pin_in),
		.capture_stb(capture_stb),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);

	// Read data: latched byte only outside debug halt
	always @* begin
		rd_data = 8'h00;
		case (rd_addr)
			`TPC_OFF_CTRL: begin
				rd_data[`TPC_MS_HI_BIT] = mode_sel_q[1];
				rd_data[`TPC_MS_LO_BIT] = mode_sel_q[0];
				rd_data[`TPC_ELS_HI_BIT] = edge_level_sel_q[1];
				rd_data[`TPC_ELS_LO_BIT] = edge_level_sel_q[0];
			end
			`TPC_OFF_VAL_HI: begin
				if (rlatch_q && !debug_halt_mode)
					rd_data = rbuf_q[15:8]; // RULE8
				else
					rd_data = chan_value_q[15:8]; // RULE12
			end
			`TPC_OFF_VAL_LO: begin
				if (rlatch_q && !debug_halt_mode)
					rd_data = rbuf_q[7:0]; // RULE8
				else
					rd_data = chan_value_q[7:0]; // RULE12
			end
			`TPC_OFF_STAT: begin
				rd_data[`TPC_ST_RLATCH_BIT] = rlatch_q;
				rd_data[`TPC_ST_GOT_HI_BIT] = got_hi_q;
				rd_data[`TPC_ST_GOT_LO_BIT] = got_lo_q;
				rd_data[`TPC_ST_PEND_BIT] = pend_q;
			end
			default: rd_data = 8'h00;
		endcase
	end

	// Control register; flag and enable bits live elsewhere
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_sel_q <= `TPC_CTRL_RST;
			edge_level_sel_q <= `TPC_CTRL_RST;
			count_up_down_q <= 1'b0;
		end else begin
			count_up_down_q <= center_pwm_select; // RULE21
			if (wr_ctrl) begin
				mode_sel_q <= {wr_data[`TPC_MS_HI_BIT], wr_data[`TPC_MS_LO_BIT]};
				edge_level_sel_q <= {wr_data[`TPC_ELS_HI_BIT], wr_data[`TPC_ELS_LO_BIT]};
			end
		end
	end

	// Read coherency; reads while halted leave it alone, a control write frees it unless a first read latches in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			rlatch_q <= 1'b0;
			rfirst_hi_q <= 1'b0;
			rbuf_q <= `TPC_VAL_RST;
		end else if ((rd_hi || rd_lo) && is_ic && !debug_halt_mode) begin // RULE11
			// A first read in the same cycle as a control write still latches
			if (!rlatch_q) begin
				rlatch_q <= 1'b1; // RULE8
				rfirst_hi_q <= rd_hi;
				rbuf_q <= chan_value_q;
			end else if (wr_ctrl || rd_hi != rfirst_hi_q) begin
				rlatch_q <= 1'b0; // RULE8 RULE9
			end
		end else if (wr_ctrl) begin
			rlatch_q <= 1'b0; // RULE9
		end
	end

	// Write buffer sequence; halt writes leave it untouched
	always @(posedge aclk) begin
		if (!aresetn) begin
			got_hi_q <= 1'b0;
			got_lo_q <= 1'b0;
			pend_q <= 1'b0;
			wbuf_hi_q <= 8'h00;
			wbuf_lo_q <= 8'h00;
		end else if (wr_ctrl) begin
			got_hi_q <= 1'b0; // RULE18
			got_lo_q <= 1'b0; // RULE18
			pend_q <= 1'b0;
		end else begin
			if (pend_load && !halt_wr)
				pend_q <= 1'b0;
			if (wr_val) begin // RULE13 RULE19
				if (wr_hi)
					wbuf_hi_q <= wr_data;
				if (wr_lo)
					wbuf_lo_q <= wr_data;
				if (completes) begin
					got_hi_q <= 1'b0;
					got_lo_q <= 1'b0;
					// Without a counter clock the pair goes straight in
					pend_q <= ~clk_off; // RULE15
				end else begin
					got_hi_q <= got_hi_q | wr_hi;
					got_lo_q <= got_lo_q | wr_lo;
				end
			end
		end
	end

	// Value register: capture, direct halt writes, buffered loads
	always @(posedge aclk) begin
		if (!aresetn) begin
			chan_value_q <= `TPC_VAL_RST; // RULE7
		end else if (capture_stb) begin
			chan_value_q <= cnt_value; // RULE22
		end else if (is_ic) begin
			chan_value_q <= chan_value_q; // RULE10
		end else if (debug_halt_mode && wr_hi) begin
			chan_value_q[15:8] <= wr_data; // RULE19 RULE20
		end else if (debug_halt_mode && wr_lo) begin
			chan_value_q[7:0] <= wr_data; // RULE19 RULE20
		end else if (wr_val && completes && clk_off) begin
			if (wr_hi)
				chan_value_q <= {wr_data, wbuf_lo_q}; // RULE15
			else
				chan_value_q <= {wbuf_hi_q, wr_data}; // RULE15
		end else if (pend_load && !wr_ctrl) begin
			// Pair buffered before the halt still lands afterwards
			chan_value_q <= {wbuf_hi_q, wbuf_lo_q}; // RULE20
		end
	end
endmodule
`default_nettype wire

// File: test/tpc_pin_model.sv
// Pin partner: an outside driver on the channel pin.
// Assumes the channel samples pin_in on aclk.
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
	input wire logic aclk,
	input wire logic ext_lvl,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_in
);
	// Channel wins the wire while it drives
	always @(posedge aclk) begin
		pin_in <= pin_oe ? pin_out : ext_lvl;
	end
endmodule
`default_nettype wire

// File: test/tpc_channel_chk.sv
// Checker: bus timing, value load causes, counter mode flag.
// Sees only channel top ports; bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module tpc_channel_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cnt_tick,
	input wire logic [1:0] counter_clock_select,
	input wire logic center_pwm_select,
	input wire logic debug_halt_mode,
	input wire logic pin_in,
	input wire logic count_up_down_q,
	input wire logic [15:0] chan_value_q
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_value_reset: assert property (
		$rose(aresetn) |-> chan_value_q == 16'h0000)
		else $error("value not cleared by reset");
	a_updown_follow: assert property (
		$past(aresetn) |-> count_up_down_q == $past(center_pwm_select))
		else $error("count mode flag wrong");
	// Clocked loads only on a counter step; pin edges allowed for capture
	a_load_cause: assert property (
		$changed(chan_value_q) && $past(aresetn) && !$past(debug_halt_mode)
		&& $past(counter_clock_select) != 2'b00
		|-> $past(cnt_tick) || $past(pin_in) != $past(pin_in, 2))
		else $error("value changed without cause");
	a_b_latency: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer late");
	a_r_latency: assert property (
		s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer late");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_w_reopen: assert property (
		s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
		else $error("write side not reopened");
endmodule
`default_nettype wire

// File: test/test_timer_channel_mode_and_value_buffer.sv
// Bench: bus master, counter stimulus, value model for one channel.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_timer_channel_mode_and_value_buffer;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0, strb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cnt_tick = 1'b0, cnt_up = 1'b1;
	logic center_pwm_select = 1'b0, debug_halt_mode = 1'b0, ext_lvl = 1'b0;
	logic [15:0] cnt_value = 16'h0, counter_modulo = 16'h0, v, w, c, ev, t;
	logic [1:0] counter_clock_select = 2'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire pin_in, pin_out, pin_oe, count_up_down_q;
	wire [15:0] chan_value_q;
	int seed, err_count, checks, i, j, k;
	always #4 aclk = ~aclk;
	tpc_channel i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cnt_value, .cnt_tick, .cnt_up,
		.counter_modulo, .counter_clock_select, .center_pwm_select, .debug_halt_mode,
		.pin_in, .pin_out, .pin_oe, .count_up_down_q, .chan_value_q);
	tpc_pin_model i_pin (.aclk, .ext_lvl, .pin_out, .pin_oe, .pin_in);
	task automatic complete_run;
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bound_ok(input logic ok);
		if (ok !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask
	// Extra edge at the end keeps strobes from being reassigned in one step
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 50);
		bound_ok(s_axi_bvalid);
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 50);
		bound_ok(s_axi_rvalid);
		chk(s_axi_rdata, exp);
		chk(s_axi_rresp, a < 32'h10 ? 2'b00 : 2'b10);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wpair(input logic [15:0] pv, input logic lo1);
		logic [15:0] old;
		old = chan_value_q;
		wr(lo1 ? 32'h8 : 32'h4, lo1 ? pv[7:0] : pv[15:8], 2'b00);
		chk(chan_value_q, old);
		wr(lo1 ? 32'h4 : 32'h8, lo1 ? pv[15:8] : pv[7:0], 2'b00);
	endtask
	task automatic tick(input logic [15:0] cv, input logic up);
		cnt_value <= cv;
		cnt_up <= up;
		cnt_tick <= 1'b1;
		@(posedge aclk);
		cnt_tick <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic cap(input logic [15:0] cv);
		cnt_value <= cv;
		ext_lvl <= !ext_lvl;
		repeat (3) @(posedge aclk);
	endtask
	initial begin
		seed = 63526;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(32'h4, 32'h0);
		rchk(32'h8, 32'h0);
		rchk(32'h10, 32'h0);
		wr(32'h10, 8'h5a, 2'b10);
		wr(32'h0, 8'h14, 2'b00);
		// Lane 0 off: write answered but dropped
		strb = 4'he;
		wr(32'h4, 8'hff, 2'b00);
		strb = 4'h1;
		rchk(32'hc, 32'h0);
		chk(chan_value_q, 16'h0000);
		for (i = 0; i < 2; i++) begin
			ev = $random(seed);
			wpair(ev, i[0]);
			chk(chan_value_q, ev);
		end
		w = $random(seed);
		wr(32'h4, w[15:8], 2'b00);
		wr(32'h0, 8'h14, 2'b00);
		rchk(32'hc, 32'h0);
		wr(32'h8, w[7:0], 2'b00);
		chk(chan_value_q, ev);
		counter_clock_select <= 2'b01;
		wr(32'h0, 8'h14, 2'b00);
		v = $random(seed);
		wpair(v, 1'b0);
		chk(chan_value_q, ev);
		tick(~v, 1'b1);
		ev = v;
		chk(chan_value_q, ev);
		for (i = 0; i < 2; i++) begin
			t = i ? 16'hffff : {8'h01, w[7:0]};
			counter_modulo <= i ? 16'h0 : t;
			wr(32'h0, 8'h28, 2'b00);
			v = $random(seed);
			wpair(v, 1'b1);
			tick(t - 16'h1, 1'b1);
			chk(chan_value_q, ev);
			tick(t, 1'b1);
			ev = v;
			chk(chan_value_q, ev);
		end
		wr(32'h0, 8'h14, 2'b00);
		v = $random(seed);
		w = $random(seed);
		wr(32'h4, v[15:8], 2'b00);
		debug_halt_mode <= 1'b1;
		wr(32'h8, w[7:0], 2'b00);
		ev[7:0] = w[7:0];
		chk(chan_value_q, ev);
		rchk(32'hc, 32'h2);
		debug_halt_mode <= 1'b0;
		wr(32'h8, v[7:0], 2'b00);
		tick(16'h0, 1'b1);
		ev = v;
		chk(chan_value_q, ev);
		wr(32'h0, 8'h10, 2'b00);
		chk(pin_oe, 1'b0);
		chk(pin_out, 1'b0);
		for (i = 1; i < 4; i++) begin
			wr(32'h0, {4'h0, i[1:0], 2'h0}, 2'b00);
			for (j = 0; j < 2; j++) begin
				c = $random(seed);
				cap(c);
				if (j ? i[1] : i[0]) ev = c;
				chk(chan_value_q, ev);
			end
			chk(pin_oe, 1'b0);
		end
		wr(32'h4, ~ev[15:8], 2'b00);
		chk(chan_value_q, ev);
		rchk(32'h4, ev[15:8]);
		c = $random(seed);
		w = ~c;
		cap(c);
		rchk(32'h8, ev[7:0]);
		rchk(32'h4, c[15:8]);
		cap(w);
		wr(32'h0, 8'h0c, 2'b00);
		rchk(32'h8, w[7:0]);
		cap(c);
		debug_halt_mode <= 1'b1;
		rchk(32'h4, c[15:8]);
		debug_halt_mode <= 1'b0;
		rchk(32'h4, w[15:8]);
		counter_clock_select <= 2'b00;
		for (i = 1; i < 4; i++) begin
			wr(32'h0, {4'h1, i[1:0], 2'h0}, 2'b00);
			wpair(16'h0040, 1'b0);
			v[0] = pin_out;
			tick(16'h0040, 1'b1);
			chk(pin_out, i == 1 ? !v[0] : i[0]);
			chk(pin_oe, 1'b1);
		end
		for (k = 0; k < 4; k++) begin
			center_pwm_select <= k[1];
			wr(32'h0, {2'h0, !k[1], 1'b0, !k[0], k[0], 2'h0}, 2'b00);
			chk(count_up_down_q, k[1]);
			wpair(16'h0030, 1'b0);
			tick(k[1] ? 16'h0030 : 16'h0000, !k[1]);
			chk(pin_out, !k[0]);
			tick(16'h0030, 1'b1);
			chk(pin_out, k[0]);
		end
		complete_run();
	end
endmodule
bind tpc_channel tpc_channel_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cnt_tick,
	.counter_clock_select, .center_pwm_select, .debug_halt_mode, .pin_in, .count_up_down_q,
	.chan_value_q);
`default_nettype wire
